// file: tlt_line_tx.v
// T1/E1 line transmitter digital control: AMI drive, shape select, idle, all-ones.
// Assumes the bit and alternate clocks are far slower than ref_clk (10 MHz).
// All control pins are asynchronous levels and pass two flops before use.
//
// Functional notes
// - Mark inputs are captured on each falling edge of the bit clock.
// - Sampled plus and minus marks become positive and negative pulses on a differential pair.
// - Pulse shape and level come only from the line length code.
// - First cable family: codes 011, 001, 010 give three ranges to 655 ft.
// - Second cable family: codes 011, 100 to 111 give five ranges.
// - Code 000 selects the 2.048 MHz international pulse template.
// - Both marks low with running clock puts the line drive off.
// - After a change of line length, all-ones or either loop request the output settles within 16 bits.
// - All-ones sends marks on alternate clock; ignored under remote loop.
// - Reference at four times bit rate bypasses jitter attenuator.
`timescale 1ns/1ps
`include "tlt_defines.vh"
module tlt_line_tx #(
  parameter SETTLE_BITS = `TLT_SETTLE_BITS,
  parameter IDLE_BITS = `TLT_IDLE_BITS
) (
  input wire ref_clk, // 10 MHz system clock
  input wire arst_n, // Async reset, active low
  input wire tx_bit_clock, // Framer bit clock
  input wire tx_plus_mark, // Unipolar positive mark
  input wire tx_minus_mark, // Unipolar negative mark
  input wire alt_clock, // External alternate clock
  input wire [2:0] line_length_code, // Line length select
  input wire all_ones_request, // Send all ones
  input wire local_loop_request, // Local loopback
  input wire remote_loop_request, // Remote loopback
  input wire ja_bypass, // Reference is 4x bit clock
  output reg line_out_a, // Positive pulse drive
  output reg line_out_b, // Negative pulse drive
  output reg line_drive_en, // Line driver enabled
  output reg [7:0] pulse_shape_sel, // One-hot pulse shape
  output reg intl_mode, // International template active
  output reg tx_settling, // Output not yet stable
  output reg remote_loop_ok // Remote loop usable
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  reg [1:0] bclk_s_r;
  reg [1:0] alt_s_r;
  reg [1:0] plus_s_r;
  reg [1:0] minus_s_r;
  reg [1:0] aor_s_r;
  reg [1:0] ll_s_r;
  reg [1:0] rl_s_r;
  reg [1:0] ja_s_r;
  reg [2:0] len_s1_r, len_s2_r;
  reg bclk_d_r, alt_d_r;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bclk_s_r <= 2'h0;
      alt_s_r <= 2'h0;
      plus_s_r <= 2'h0;
      minus_s_r <= 2'h0;
      aor_s_r <= 2'h0;
      ll_s_r <= 2'h0;
      rl_s_r <= 2'h0;
      ja_s_r <= 2'h0;
      len_s1_r <= 3'h0;
      len_s2_r <= 3'h0;
      bclk_d_r <= 1'b0;
      alt_d_r <= 1'b0;
    end else begin
      bclk_s_r <= {bclk_s_r[0], tx_bit_clock};
      alt_s_r <= {alt_s_r[0], alt_clock};
      // Marks sampled with two-flop delay equal to the clock's, so the group stays aligned
      plus_s_r <= {plus_s_r[0], tx_plus_mark};
      minus_s_r <= {minus_s_r[0], tx_minus_mark};
      aor_s_r <= {aor_s_r[0], all_ones_request};
      ll_s_r <= {ll_s_r[0], local_loop_request};
      rl_s_r <= {rl_s_r[0], remote_loop_request};
      ja_s_r <= {ja_s_r[0], ja_bypass};
      // Length bits may skew while moving; a torn code only restarts settling
      len_s1_r <= line_length_code;
      len_s2_r <= len_s1_r;
      bclk_d_r <= bclk_s_r[1];
      alt_d_r <= alt_s_r[1];
    end
  end
  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  // Edges are found one flop after the synchroniser, so each costs 3 ref cycles
  // Limitation: bit clock high and low must each last at least 3 ref cycles
  wire bclk_fall = bclk_d_r & ~bclk_s_r[1];
  wire alt_rise = ~alt_d_r & alt_s_r[1];
  wire aos_act = aor_s_r[1] & ~rl_s_r[1];
  wire bit_tick = aos_act ? alt_rise : bclk_fall;
  // ----------------------------------------
  // Control change detect and settling
  // ----------------------------------------
  reg [2:0] len_q_r;
  reg aos_q_r;
  reg ll_q_r;
  reg rl_q_r;
  reg [4:0] settle_cnt_r;
  reg [4:0] idle_cnt_r;
  reg mark_pol_r;
  // A toggle of line length, all-ones or either loop request restarts the settling window
  wire ctl_chg = (len_q_r != len_s2_r) |
                 (aos_q_r != aor_s_r[1]) |
                 (ll_q_r != ll_s_r[1]) |
                 (rl_q_r != rl_s_r[1]);
  // ----------------------------------------
  // Shape decode
  // ----------------------------------------
  reg [7:0] shape_nxt;
  always @* begin
    case (len_s2_r)
      `TLT_LEN_INTL: shape_nxt = `TLT_SHAPE_INTL;
      `TLT_LEN_SHORT: shape_nxt = `TLT_SHAPE_0_133;
      `TLT_LEN_A_MID: shape_nxt = `TLT_SHAPE_220_440;
      `TLT_LEN_A_LONG: shape_nxt = `TLT_SHAPE_440_655;
      `TLT_LEN_B_R2: shape_nxt = `TLT_SHAPE_133_266;
      `TLT_LEN_B_R3: shape_nxt = `TLT_SHAPE_266_399;
      `TLT_LEN_B_R4: shape_nxt = `TLT_SHAPE_399_533;
      `TLT_LEN_B_R5: shape_nxt = `TLT_SHAPE_533_655;
      default: shape_nxt = `TLT_SHAPE_INTL;
    endcase
  end
  // ----------------------------------------
  // Line encoder
  // ----------------------------------------
  reg mark_p, mark_m;
  always @* begin
    mark_p = 1'b0;
    mark_m = 1'b0;
    if (aos_act) begin
      // Continuous marks alternate polarity
      mark_p = ~mark_pol_r;
      mark_m = mark_pol_r;
    end else if (plus_s_r[1] & ~minus_s_r[1]) begin
      mark_p = 1'b1;
    end else if (minus_s_r[1] & ~plus_s_r[1]) begin
      mark_m = 1'b1;
    end
  end
  // ----------------------------------------
  // Control tracking and status
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      len_q_r <= 3'h0;
      aos_q_r <= 1'b0;
      ll_q_r <= 1'b0;
      rl_q_r <= 1'b0;
      pulse_shape_sel <= `TLT_SHAPE_INTL;
      intl_mode <= 1'b1;
      remote_loop_ok <= 1'b1;
    end else begin
      len_q_r <= len_s2_r;
      aos_q_r <= aor_s_r[1];
      ll_q_r <= ll_s_r[1];
      rl_q_r <= rl_s_r[1];
      pulse_shape_sel <= shape_nxt;
      intl_mode <= (len_s2_r == `TLT_LEN_INTL);
      // Status only; the loopback path itself lives elsewhere
      remote_loop_ok <= ~ja_s_r[1];
    end
  end
  // ----------------------------------------
  // Settling counter
  // ----------------------------------------
  // Counts bit ticks, so a stopped bit clock, or a stopped alternate clock under all-ones, keeps the flag high
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_r <= SETTLE_BITS[4:0];
      tx_settling <= 1'b1;
    end else begin
      if (ctl_chg) begin
        settle_cnt_r <= SETTLE_BITS[4:0];
      end else if (bit_tick && settle_cnt_r != 5'h0) begin
        settle_cnt_r <= settle_cnt_r - 5'h1;
      end
      tx_settling <= ctl_chg | (settle_cnt_r != 5'h0);
    end
  end
  // ----------------------------------------
  // Line output and idle
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt_r <= 5'h0;
      mark_pol_r <= 1'b0;
      line_out_a <= 1'b0;
      line_out_b <= 1'b0;
      line_drive_en <= 1'b0;
    end else if (bit_tick) begin
      line_out_a <= mark_p;
      line_out_b <= mark_m;
      // Keep last polarity, not a mark count, so all-ones carries on alternating
      if (mark_p) begin
        mark_pol_r <= 1'b1;
      end else if (mark_m) begin
        mark_pol_r <= 1'b0;
      end
      // Idle after a run of spaces so single zeros keep the driver on
      if (aos_act || mark_p || mark_m) begin
        idle_cnt_r <= 5'h0;
        line_drive_en <= 1'b1;
      end else if (idle_cnt_r != IDLE_BITS[4:0]) begin
        idle_cnt_r <= idle_cnt_r + 5'h1;
      end else begin
        line_drive_en <= 1'b0;
      end
    end
  end
endmodule

// file: tlt_defines.vh
// Constants for the T1/E1 transmit control block.
// Included by tlt_line_tx.v; definitions only.
`ifndef TLT_DEFINES_VH
`define TLT_DEFINES_VH
// ----------------------------------------
// Line length codes
// ----------------------------------------
`define TLT_LEN_INTL 3'h0
`define TLT_LEN_A_MID 3'h1
`define TLT_LEN_A_LONG 3'h2
`define TLT_LEN_SHORT 3'h3
`define TLT_LEN_B_R2 3'h4
`define TLT_LEN_B_R3 3'h5
`define TLT_LEN_B_R4 3'h6
`define TLT_LEN_B_R5 3'h7
// ----------------------------------------
// Pulse shape selects (one-hot, 8 shapes)
// ----------------------------------------
`define TLT_SHAPE_INTL 8'h01
`define TLT_SHAPE_0_133 8'h02
`define TLT_SHAPE_220_440 8'h04
`define TLT_SHAPE_440_655 8'h08
`define TLT_SHAPE_133_266 8'h10
`define TLT_SHAPE_266_399 8'h20
`define TLT_SHAPE_399_533 8'h40
`define TLT_SHAPE_533_655 8'h80
// ----------------------------------------
// Timing
// ----------------------------------------
`define TLT_SETTLE_BITS 16
`define TLT_IDLE_BITS 16
`define TLT_LINE_RESET 2'h0
`endif

// file: tlt_monitor.sv
// Port checker for tlt_line_tx.
// Bound to the design by the testbench; watches outputs against inputs in one clock domain.
`timescale 1ns/1ps
module tlt_monitor #(parameter SETTLE_BITS = 16, parameter IDLE_BITS = 16) (
  input wire ref_clk, input wire arst_n, // Clock and reset
  input wire tx_bit_clock, input wire tx_plus_mark, input wire tx_minus_mark, // Framer side
  input wire [2:0] line_length_code, input wire all_ones_request, input wire ja_bypass, // Controls
  input wire line_out_a, input wire line_out_b, input wire line_drive_en, // Line drive
  input wire [7:0] pulse_shape_sel, input wire intl_mode, input wire tx_settling, input wire remote_loop_ok // Status
);
  // Shape bit per code, code 7 first
  localparam [23:0] SHAPE_IDX = {3'd7, 3'd6, 3'd5, 3'd4, 3'd1, 3'd3, 3'd2, 3'd0};
  wire [7:0] exp_shape = 8'h01 << SHAPE_IDX[line_length_code * 3 +: 3];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_onehot; $onehot(pulse_shape_sel); endproperty
  a_onehot: assert property (p_onehot) else $error("shape select not one-hot");
  property p_intl; intl_mode == (pulse_shape_sel == 8'h01); endproperty
  a_intl: assert property (p_intl) else $error("intl mode disagrees with shape");
  property p_code_map; $stable(line_length_code)[*6] |-> pulse_shape_sel == exp_shape; endproperty
  a_code_map: assert property (p_code_map) else $error("wrong shape for code");
  property p_no_both; !(line_out_a && line_out_b); endproperty
  a_no_both: assert property (p_no_both) else $error("both line outputs high");
  property p_drive; (line_out_a || line_out_b) |-> line_drive_en; endproperty
  a_drive: assert property (p_drive) else $error("pulse with driver off");
  property p_plus; $fell(tx_bit_clock) && tx_plus_mark && !tx_minus_mark && !all_ones_request |-> ##[3:6] line_out_a;
  endproperty
  a_plus: assert property (p_plus) else $error("plus mark not sent");
  property p_minus; $fell(tx_bit_clock) && tx_minus_mark && !tx_plus_mark && !all_ones_request |-> ##[3:6] line_out_b;
  endproperty
  a_minus: assert property (p_minus) else $error("minus mark not sent");
  property p_settle; $changed(line_length_code) |-> ##[1:3] tx_settling; endproperty
  a_settle: assert property (p_settle) else $error("settling not raised");
  property p_remote; ja_bypass[*4] |-> !remote_loop_ok; endproperty
  a_remote: assert property (p_remote) else $error("remote loop allowed in bypass");
endmodule

// file: tlt_framer.sv
// Framer model: bit clock and unipolar marks.
// Drives on ref_clk falling edges; the bit clock stands low until run is set.
`timescale 1ns/1ps
module tlt_framer (
  input wire ref_clk, input wire run, input wire send_marks, // Clock and mode
  output reg tx_bit_clock, output reg tx_plus_mark, output reg tx_minus_mark // To the transmitter
);
  integer ph;
  reg r;
  initial begin
    ph = 0;
    tx_bit_clock = 0;
    tx_plus_mark = 0;
    tx_minus_mark = 0;
  end
  // Five ref cycles per half bit, above the synchroniser minimum
  always @(negedge ref_clk) if (run) begin
    ph = (ph == 9) ? 0 : ph + 1;
    tx_bit_clock <= (ph < 5);
    if (ph == 0) begin
      r = $urandom % 2;
      tx_plus_mark <= send_marks & r;
      tx_minus_mark <= send_marks & ~r;
    end
  end
endmodule

// file: t1_e1_line_transmit_control_test.sv
// Self-checking bench for tlt_line_tx with framer model and port checker.
// Assumes tlt_line_tx.v, tlt_monitor.sv and tlt_framer.sv are compiled with it.
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module t1_e1_line_transmit_control_test;
  reg ref_clk = 0, arst_n = 0, alt_clock = 0, all_ones_request = 0, local_loop_request = 0;
  reg remote_loop_request = 0, ja_bypass = 0, run = 0, send_marks = 1;
  reg [2:0] line_length_code = 0;
  wire tx_bit_clock, tx_plus_mark, tx_minus_mark, line_out_a, line_out_b, line_drive_en;
  wire intl_mode, tx_settling, remote_loop_ok;
  wire [7:0] pulse_shape_sel;
  integer bad_count = 0, check_count = 0, i;
  reg last_a = 0;
  // Polarity of the last pulse on the line; the next mark must take the other
  always @(posedge ref_clk) if (line_out_a ^ line_out_b) last_a <= line_out_a;
  initial forever #50 ref_clk = ~ref_clk;
  tlt_framer tlt_framer_inst (.ref_clk(ref_clk), .run(run), .send_marks(send_marks),
    .tx_bit_clock(tx_bit_clock), .tx_plus_mark(tx_plus_mark), .tx_minus_mark(tx_minus_mark));
  // Short idle count keeps the low-power case quick
  tlt_line_tx #(.IDLE_BITS(2)) tlt_line_tx_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .tx_bit_clock(tx_bit_clock), .tx_plus_mark(tx_plus_mark), .tx_minus_mark(tx_minus_mark),
    .alt_clock(alt_clock), .line_length_code(line_length_code), .all_ones_request(all_ones_request),
    .local_loop_request(local_loop_request), .remote_loop_request(remote_loop_request), .ja_bypass(ja_bypass),
    .line_out_a(line_out_a), .line_out_b(line_out_b), .line_drive_en(line_drive_en),
    .pulse_shape_sel(pulse_shape_sel), .intl_mode(intl_mode), .tx_settling(tx_settling),
    .remote_loop_ok(remote_loop_ok));
  function [7:0] shape_of(input [2:0] c);
    shape_of = (c == 3'h3) ? 8'h02 : (c == 3'h0) ? 8'h01 : (c < 3'h3) ? 8'h02 << c : 8'h01 << c;
  endfunction
  task wrap_up;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task alt_burst(input reg marks);
    integer k;
    reg st;
    st = last_a;
    for (k = 0; k < 4; k++) begin
      alt_clock = 1;
      repeat (6) @(negedge ref_clk);
      `CHK("line_out", marks ? ((st ^ k[0]) ? 2'b01 : 2'b10) : 2'b00, {line_out_a, line_out_b})
      alt_clock = 0;
      repeat (6) @(negedge ref_clk);
    end
  endtask
  initial begin
    #500000;
    bad_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'hb405_54bb));
    repeat (8) @(negedge ref_clk);
    `CHK("reset line_out", 2'b00, {line_out_a, line_out_b})
    `CHK("reset drive_en", 1'b0, line_drive_en)
    `CHK("reset shape", 8'h01, pulse_shape_sel)
    arst_n = 1;
    run = 1;
    for (i = 0; i < 8; i++) begin
      line_length_code = i[2:0];
      local_loop_request = $urandom % 2;
      repeat (6) @(negedge ref_clk);
      `CHK("pulse_shape_sel", shape_of(i[2:0]), pulse_shape_sel)
      `CHK("intl_mode", i == 0, intl_mode)
      `CHK("tx_settling", 1'b1, tx_settling)
    end
    repeat (200) @(negedge ref_clk);
    `CHK("tx_settling", 1'b0, tx_settling)
    `CHK("drive_en", 1'b1, line_drive_en)
    send_marks = 0;
    repeat (60) @(negedge ref_clk);
    `CHK("idle drive_en", 1'b0, line_drive_en)
    `CHK("idle line_out", 2'b00, {line_out_a, line_out_b})
    send_marks = 1;
    all_ones_request = 1;
    alt_burst(1'b1);
    send_marks = 0;
    remote_loop_request = 1;
    repeat (40) @(negedge ref_clk);
    alt_burst(1'b0);
    ja_bypass = 1;
    repeat (4) @(negedge ref_clk);
    `CHK("remote_loop_ok", 1'b0, remote_loop_ok)
    wrap_up;
  end
endmodule
bind tlt_line_tx tlt_monitor #(.SETTLE_BITS(SETTLE_BITS), .IDLE_BITS(IDLE_BITS)) tlt_monitor_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .tx_bit_clock(tx_bit_clock), .tx_plus_mark(tx_plus_mark),
  .tx_minus_mark(tx_minus_mark), .line_length_code(line_length_code), .all_ones_request(all_ones_request),
  .ja_bypass(ja_bypass), .line_out_a(line_out_a), .line_out_b(line_out_b), .line_drive_en(line_drive_en),
  .pulse_shape_sel(pulse_shape_sel), .intl_mode(intl_mode), .tx_settling(tx_settling),
  .remote_loop_ok(remote_loop_ok));
